//--- rtl/epgm_pkg.sv
// Package for the one-time-programmable memory programmer: timing, levels, types
package epgm_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PULSE_NOM_US   = 100;   // Nominal program_pulse_time
  localparam int PULSE_MIN_US   = 95;
  localparam int PULSE_MAX_US   = 105;
  localparam int SETUP_US       = 2;     // Address, data, supply and output-enable setups
  localparam int HOLD_US        = 2;     // Data hold after the strobe
  localparam int READ_WAIT_NS   = 150;   // Data valid after output enable
  localparam int FLOAT_WAIT_NS  = 130;   // Output float after output enable high
  localparam int PULSE_CYC      = (PULSE_NOM_US * 1000) / CLK_PERIOD_NS;
  localparam int PULSE_MIN_CYC  = (PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MAX_CYC  = (PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int SETUP_CYC      = (SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC       = (HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC       = (READ_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC      = (FLOAT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Algorithm counts and supply levels
  // ****************************************************************
  localparam int          MAX_RETRY   = 10;
  localparam logic [1:0]  SUPPLY_OFF  = 2'h0;
  localparam logic [1:0]  SUPPLY_READ = 2'h1;   // 5.0 V
  localparam logic [1:0]  SUPPLY_PROG = 2'h2;   // Core 6.5 V, programming 13.0 V
  localparam logic [1:0]  SUPPLY_ID   = 2'h3;   // id_select_level, 11.5 V to 12.5 V

  // ****************************************************************
  // Pin bundles
  // ****************************************************************
  typedef struct packed {
    logic       chip_sel_n;   // Program strobe when supplies are raised
    logic       out_en_n;
    logic [1:0] core_supply;  // Supply level request codes
    logic [1:0] prog_supply;
    logic [1:0] id_select;    // SUPPLY_ID raises id_select_line
  } epgm_ctl_t;

  typedef enum logic [10:0] {
    S_IDLE   = 11'h001,
    S_PWRUP  = 11'h002,
    S_SETUP  = 11'h004,
    S_PULSE  = 11'h008,
    S_HOLD   = 11'h010,
    S_VREAD  = 11'h020,
    S_VCHK   = 11'h040,
    S_FLOAT  = 11'h080,
    S_PWRDN  = 11'h100,
    S_FINAL  = 11'h200,
    S_IDREAD = 11'h400
  } epgm_state_t;

endpackage

//--- rtl/epgm_programmer.sv
// Programmer that burns, verifies and identifies a byte-wide OTP memory
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Program strobe low 95 to 105 us
// - Address starts at first location
// - Raise core 6.5 V, programming 13.0 V
// - First pass: one strobe, no verify
// - Second pass: verify, retry up to ten
// - Ten failed retries fail whole part
// - Verified byte advances to next address
// - Lower to 5.0 V, reread, report result
// - Core supply on first when burning (with programming supply for id read), off last
// - Hold id line at raised level
module epgm_programmer
  import epgm_pkg::*;
#(
  parameter int ADDR_W     = 15,
  parameter int PULSE_CYCS = PULSE_CYC
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Job control
  input  wire logic              start_prog,
  input  wire logic              start_id,
  input  wire logic [ADDR_W-1:0] last_addr,
  output logic                   busy,
  output logic                   done,
  output logic                   pass,
  output logic [7:0]             id_maker,
  output logic [7:0]             id_type,
  // Image source: byte intended at mem_addr, valid in the same cycle
  input  wire logic [7:0]        image_data,
  // Memory pins
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [7:0]             data_out,
  output logic                   data_oe_n,
  input  wire logic [7:0]        data_in,
  output epgm_ctl_t              ctl
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (PULSE_CYCS < 1 || PULSE_CYCS > 65535)
    $error("PULSE_CYCS out of range");
  if (ADDR_W < 1 || ADDR_W > 24)
    $error("ADDR_W out of range");

  // ****************************************************************
  // State
  // ****************************************************************
  epgm_state_t state;
  logic [15:0] timer;
  logic [3:0]  retries;
  logic        verify_pass;   // Low during the blind first pass
  logic        final_pass;    // High during the 5.0 V reread
  logic        id_half;

  function automatic logic [15:0] cyc(input int n);
    return n[15:0] - 16'h0001;
  endfunction

  wire timer_done = (timer == 16'h0000);
  wire at_last    = (mem_addr == last_addr);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // One process owns the flow so that pin moves and their timers never drift apart
  always_ff @(posedge mclk) begin
    if (reset) begin
      state       <= S_IDLE;
      timer       <= 16'h0000;
      retries     <= 4'h0;
      verify_pass <= 1'b0;
      final_pass  <= 1'b0;
      id_half     <= 1'b0;
      busy        <= 1'b0;
      done        <= 1'b0;
      pass        <= 1'b0;
      id_maker    <= 8'h00;
      id_type     <= 8'h00;
      mem_addr    <= '0;
      data_out    <= 8'h00;
      data_oe_n   <= 1'b1;
      ctl         <= '{1'b1, 1'b1, SUPPLY_OFF, SUPPLY_OFF, SUPPLY_OFF};
    end else begin
      done <= 1'b0;
      if (!timer_done) begin
        timer <= timer - 16'h0001;
      end else begin
        case (state)
          S_IDLE: begin
            if (start_prog) begin
              busy             <= 1'b1;
              pass             <= 1'b0;
              mem_addr         <= '0;
              verify_pass      <= 1'b0;
              final_pass       <= 1'b0;
              ctl.core_supply  <= SUPPLY_PROG;
              timer            <= cyc(SETUP_CYC);
              state            <= S_PWRUP;
            end else if (start_id) begin
              busy          <= 1'b1;
              mem_addr      <= '0;
              id_half       <= 1'b0;
              ctl.core_supply <= SUPPLY_READ;
              ctl.prog_supply <= SUPPLY_READ;
              ctl.id_select <= SUPPLY_ID;
              ctl.chip_sel_n <= 1'b0;
              ctl.out_en_n  <= 1'b0;
              timer         <= cyc(SETUP_CYC + READ_CYC);
              state         <= S_IDREAD;
            end
          end
          S_PWRUP: begin
            // Programming supply follows the core supply after its setup time
            ctl.prog_supply <= SUPPLY_PROG;
            timer           <= cyc(SETUP_CYC);
            state           <= S_SETUP;
          end
          S_SETUP: begin
            data_out   <= image_data;
            data_oe_n  <= 1'b0;
            ctl.out_en_n <= 1'b1;
            timer      <= cyc(SETUP_CYC);
            state      <= S_PULSE;
          end
          S_PULSE: begin
            if (ctl.chip_sel_n) begin
              ctl.chip_sel_n <= 1'b0;
              timer          <= cyc(PULSE_CYCS);
            end else begin
              ctl.chip_sel_n <= 1'b1;
              timer          <= cyc(HOLD_CYC);
              state          <= S_HOLD;
            end
          end
          S_HOLD: begin
            data_oe_n <= 1'b1;
            if (!verify_pass) begin
              // Blind pass: one strobe each, no readback
              if (at_last) begin
                verify_pass <= 1'b1;
                retries     <= 4'h0;
                mem_addr    <= '0;
                timer       <= cyc(SETUP_CYC);
                state       <= S_VREAD;
              end else begin
                mem_addr <= mem_addr + 1'b1;
                state    <= S_SETUP;
              end
            end else begin
              retries <= retries + 4'h1;
              timer   <= cyc(SETUP_CYC);
              state   <= S_VREAD;
            end
          end
          S_VREAD: begin
            ctl.chip_sel_n <= 1'b0;
            ctl.out_en_n   <= 1'b0;
            timer          <= cyc(READ_CYC);
            state          <= S_VCHK;
          end
          S_VCHK: begin
            ctl.chip_sel_n <= 1'b1;
            ctl.out_en_n   <= 1'b1;
            timer          <= cyc(FLOAT_CYC);
            state          <= S_FLOAT;
            if (data_in != image_data) begin
              if (final_pass || retries == MAX_RETRY[3:0]) begin
                pass  <= 1'b0;
                state <= S_PWRDN;
              end else begin
                state <= S_SETUP;
              end
            end else if (at_last) begin
              if (final_pass) begin
                pass <= 1'b1;
              end else begin
                final_pass      <= 1'b1;
                ctl.prog_supply <= SUPPLY_READ;
                ctl.core_supply <= SUPPLY_READ;
                mem_addr        <= '0;
                timer           <= cyc(SETUP_CYC);
              end
              state <= final_pass ? S_PWRDN : S_FINAL;
            end else begin
              mem_addr <= mem_addr + 1'b1;
              retries  <= 4'h0;
              state    <= final_pass ? S_FINAL : S_VREAD;
            end
          end
          S_FINAL: begin
            timer <= cyc(SETUP_CYC);
            state <= S_VREAD;
          end
          S_PWRDN: begin
            // Programming supply leaves first, core after its hold
            if (ctl.prog_supply != SUPPLY_OFF) begin
              ctl.prog_supply <= SUPPLY_OFF;
              timer           <= cyc(SETUP_CYC);
            end else begin
              ctl.core_supply <= SUPPLY_OFF;
              busy            <= 1'b0;
              done            <= 1'b1;
              state           <= S_IDLE;
            end
          end
          S_IDREAD: begin
            if (!id_half) begin
              id_maker <= data_in;
              id_half  <= 1'b1;
              mem_addr <= ADDR_W'(1);
              timer    <= cyc(READ_CYC);
            end else begin
              id_type        <= data_in;
              ctl.chip_sel_n <= 1'b1;
              ctl.out_en_n   <= 1'b1;
              ctl.id_select  <= SUPPLY_OFF;
              ctl.prog_supply <= SUPPLY_READ;
              pass           <= 1'b1;
              mem_addr       <= '0;
              timer          <= cyc(FLOAT_CYC);
              state          <= S_PWRDN;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- verification/epgm_programmer_assertions.sv
// Checker of the programmer's pin sequencing
`timescale 1ns/1ps
`default_nettype none
module epgm_programmer_checker
  import epgm_pkg::*;
#(
  parameter int ADDR_W     = 15,
  parameter int PULSE_CYCS = PULSE_CYC
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              reset,
  // Job control
  input wire logic              start_prog,
  input wire logic              start_id,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              pass,
  // Memory pins
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              data_oe_n,
  input wire epgm_ctl_t         ctl
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ****************
  // Strobe bookkeeping
  // ****************
  logic [15:0]       low_len;
  logic [3:0]        hits;
  logic              was_sel_n;
  logic              seen;
  logic [ADDR_W-1:0] was_addr;
  wire logic         burn = !ctl.chip_sel_n && was_sel_n && ctl.out_en_n;
  // Strobe low time, strobes at one address, first strobe of a run seen
  always_ff @(posedge mclk) begin
    was_sel_n <= reset | ctl.chip_sel_n;
    was_addr  <= mem_addr;
    low_len   <= (reset | ctl.chip_sel_n) ? 16'h0 : low_len + 16'h1;
    seen      <= busy & !reset & (seen | burn);
    hits      <= (reset | !busy | (mem_addr != was_addr)) ? 4'h0 : hits + {3'h0, burn};
  end
  pulse_width_a: assert property ($rose(ctl.chip_sel_n) && $past(ctl.out_en_n)
    |-> low_len == PULSE_CYCS) else $error("program strobe width wrong");
  first_addr_a: assert property (burn && !seen |-> mem_addr == '0)
    else $error("first strobe not at first location");
  supply_prog_a: assert property (!ctl.chip_sel_n && ctl.out_en_n |->
    ctl.core_supply == SUPPLY_PROG && ctl.prog_supply == SUPPLY_PROG)
    else $error("strobe without programming supplies");
  retry_limit_a: assert property (hits <= 4'hb)
    else $error("too many strobes at one address");
  supply_order_a: assert property (ctl.prog_supply != SUPPLY_OFF |->
    ctl.core_supply != SUPPLY_OFF) else $error("programming supply without core");
  read_cycle_a: assert property (!ctl.out_en_n |-> data_oe_n && !ctl.chip_sel_n)
    else $error("read with wrong strobes or driven data");
  id_level_a: assert property ($rose(busy) && $past(start_id) && !$past(start_prog)
    |-> ##[1:400] ctl.id_select == SUPPLY_ID) else $error("id line never raised");
  id_safe_a: assert property (ctl.id_select == SUPPLY_ID |->
    ctl.prog_supply != SUPPLY_PROG && data_oe_n) else $error("programming in id mode");
  done_pulse_a: assert property (done |=> !done && !busy)
    else $error("done not a single pulse");
  cover property (done && !pass);
  cover property (hits == 4'hb);
  cover property (ctl.id_select == SUPPLY_ID && !ctl.out_en_n);
endmodule
bind epgm_programmer epgm_programmer_checker #(.ADDR_W(ADDR_W), .PULSE_CYCS(PULSE_CYCS))
  i_chk (.mclk(mclk), .reset(reset), .start_prog(start_prog), .start_id(start_id),
  .busy(busy), .done(done), .pass(pass), .mem_addr(mem_addr), .data_oe_n(data_oe_n),
  .ctl(ctl));
`default_nettype wire

//--- verification/epgm_mem_model.sv
// Behavioural model of the one-time-programmable memory
`timescale 1ns/1ps
`default_nettype none
module epgm_mem_model
  import epgm_pkg::*;
#(
  parameter int         ADDR_W   = 4,
  parameter logic [7:0] MAKER_ID = 8'h5a,  // Arbitrary value
  parameter logic [7:0] TYPE_ID  = 8'ha5   // Arbitrary value
) (
  // Pins
  input  wire logic              mclk,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [7:0]        data_out,
  input  wire logic              data_oe_n,
  input  wire epgm_ctl_t         ctl,
  output logic [7:0]             data_in
);
  // ****************
  // Cell array
  // ****************
  logic [7:0] mem  [2**ADDR_W];
  int         need [2**ADDR_W];  // Strobes before a cell takes, set by the bench
  int         hits [2**ADDR_W];
  logic [7:0] last = 8'h00;
  wire logic  rd   = !ctl.chip_sel_n && !ctl.out_en_n;
  // Cells take only under programming supply with data driven; bits only clear
  always @(posedge ctl.chip_sel_n) begin
    if (ctl.out_en_n && !data_oe_n && ctl.prog_supply == SUPPLY_PROG) begin
      hits[mem_addr] = hits[mem_addr] + 1;
      if (hits[mem_addr] >= need[mem_addr]) begin
        mem[mem_addr] = mem[mem_addr] & data_out;
      end
    end
  end
  // Released bus shows the inverse of the last byte, never a stale copy
  assign data_in = !rd ? ~last : (ctl.id_select == SUPPLY_ID) ?
    (mem_addr[0] ? TYPE_ID : MAKER_ID) : mem[mem_addr];
  // Remember what was last put on the bus
  always @(posedge mclk) begin
    if (rd) last <= data_in;
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the programmer: id read and program runs
`timescale 1ns/1ps
`default_nettype none
module testbench
  import epgm_pkg::*;
();
  localparam int AW = 4;
  localparam logic [7:0] MAKER = 8'h3c;  // Arbitrary value
  localparam logic [7:0] KIND  = 8'hc3;  // Arbitrary value
  logic          mclk = 1'b0, reset = 1'b1, start_prog = 1'b0, start_id = 1'b0;
  logic [AW-1:0] last_addr = '0, mem_addr;
  logic          busy, done, pass, data_oe_n;
  logic [7:0]    id_maker, id_type, image_data, data_out, data_in;
  logic [7:0]    img [2**AW];
  epgm_ctl_t     ctl;
  logic [31:0]   seed = 32'h0000003b;
  int            miscompares = 0, num_checks = 0, lst;
  assign image_data = img[mem_addr];
  always #5 mclk = ~mclk;
  epgm_programmer #(.ADDR_W(AW), .PULSE_CYCS(50)) i_epgm_programmer (.mclk(mclk),
    .reset(reset), .start_prog(start_prog), .start_id(start_id), .last_addr(last_addr),
    .busy(busy), .done(done), .pass(pass), .id_maker(id_maker), .id_type(id_type),
    .image_data(image_data), .mem_addr(mem_addr), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_in(data_in), .ctl(ctl));
  epgm_mem_model #(.ADDR_W(AW), .MAKER_ID(MAKER), .TYPE_ID(KIND)) i_epgm_mem_model (
    .mclk(mclk), .mem_addr(mem_addr), .data_out(data_out), .data_oe_n(data_oe_n),
    .ctl(ctl), .data_in(data_in));
  // Xorshift source, repeatable from its fixed seed
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // A part passes unless some burnt byte needs more than the blind strobe plus ten
  function automatic logic exp_pass(input int last);
    exp_pass = 1'b1;
    for (int a = 0; a <= last; a++) begin
      if (i_epgm_mem_model.need[a] > MAX_RETRY + 1 && img[a] != 8'hff) exp_pass = 1'b0;
    end
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Fresh blank part, new image, then one start pulse and a bounded wait for done
  task automatic run(input logic id, input int last, input int need0);
    int n;
    @(posedge mclk);
    for (int a = 0; a < 2**AW; a++) begin
      img[a] = (a == 0) ? 8'h00 : 8'(rnd());  // Address zero burns every bit
      i_epgm_mem_model.mem[a]  = 8'hff;
      i_epgm_mem_model.hits[a] = 0;
      i_epgm_mem_model.need[a] = (a == 0) ? need0 : 1 + int'(rnd() % 32'h4);
    end
    last_addr  <= last[AW-1:0];
    start_prog <= !id;
    start_id   <= id;
    @(posedge mclk);
    start_prog <= 1'b0;
    start_id   <= 1'b0;
    for (n = 0; n < 60000 && done !== 1'b1; n++) @(negedge mclk);
    if (n == 60000) begin
      miscompares++;
      give_verdict();
    end
  endtask
  // Id read, then boundary retry counts, a single-location part and random images
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    run(1'b1, 1, 1);
    chk("maker", MAKER, id_maker);
    chk("kind", KIND, id_type);
    chk("id pass", 8'h01, {7'h0, pass});
    for (int k = 0; k < 5; k++) begin
      lst = (k == 2) ? 0 : 1 + int'(rnd() % 32'h7);
      // A single location at the boundary count takes all eleven strobes at one address
      run(1'b0, lst, (k == 0 || k == 2) ? 11 : (k == 1) ? 12 : 1 + int'(rnd() % 32'h4));
      chk("pass", {7'h0, exp_pass(lst)}, {7'h0, pass});
      chk("beyond", 8'hff, i_epgm_mem_model.mem[lst + 1]);
      for (int a = 0; a <= lst; a++) begin
        if (exp_pass(lst)) chk("cell", img[a], i_epgm_mem_model.mem[a]);
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
